// *** hw/urt_top.v ***
// UART control registers, data register, baud generator and serial engines.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "urt_defs.vh"

module urt_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire uart_clk_off,
  input wire rx_pin_i,
  output reg tx_pin_o,
  output reg tx_pin_oe_n,
  output reg rx_pin_own,
  output reg uart_irq
);

  //--------------------------------------------------------------------
  // State codes
  //--------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_BITS = 2'd2;
  localparam [1:0] ST_STOP = 2'd3;

  //--------------------------------------------------------------------
  // Registers and flags
  //--------------------------------------------------------------------
  reg [7:0] ctrl_one_reg; // Master enable, format and ninth-bit control.
  reg [7:0] uart_ctrl_two_reg; // Enables and interrupt gates.
  reg [7:0] baud_divisor_reg; // Baud divisor N.
  reg [7:0] tx_hold_reg; // Transmit holding byte.
  reg [7:0] rx_data_reg; // Last accepted received byte.
  reg rx_bit8_reg; // Ninth received bit.
  reg tx_empty_reg; // Holding register empty.
  reg tx_idle_reg; // Transmitter idle.
  reg rx_full_reg; // Received byte waiting.
  reg rx_overrun_reg; // A word was lost because the byte was not read.
  reg par_err_reg; // Parity mismatch on the last accepted word.
  reg wake_flag_reg; // Wake-up request, sticky.
  wire rx_idle; // Receiver between frames, shown in status.

  wire master_en = ctrl_one_reg[`URT_C1_MASTER];
  wire nine_bit_sel = ctrl_one_reg[`URT_C1_NINE];
  wire parity_enable = ctrl_one_reg[`URT_C1_PAR_EN];
  wire parity_type = ctrl_one_reg[`URT_C1_PAR_ODD];
  wire stop_bits_sel = ctrl_one_reg[`URT_C1_STOP2];
  wire tx_bit8 = ctrl_one_reg[`URT_C1_TXB8];
  wire tx_run = uart_ctrl_two_reg[`URT_C2_TX_ENABLE] & master_en;
  wire rx_run = uart_ctrl_two_reg[`URT_C2_RX_ENABLE] & master_en & ~uart_clk_off;
  wire [3:0] nbits = nine_bit_sel ? `URT_NBITS_NINE : `URT_NBITS_EIGHT;

  //--------------------------------------------------------------------
  // AXI4-Lite slave
  //--------------------------------------------------------------------
  reg aw_full_reg; // Write address taken, waiting for data.
  reg w_full_reg; // Write data taken, waiting for address.
  reg [7:0] aw_addr_reg;
  reg [7:0] w_data_reg;
  reg w_lane0_reg; // Byte lane 0 enabled; registers live in it.
  reg rd_stat_reg; // Pulse: status register was read.
  reg rd_data_reg; // Pulse: data register was read.
  wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire wr_en = wr_fire & w_lane0_reg;
  wire [7:0] status = {1'b0, wake_flag_reg, rx_idle, par_err_reg, rx_overrun_reg,
                       rx_full_reg, tx_idle_reg, tx_empty_reg};
  wire aw_ok = (aw_addr_reg == `URT_OFF_CTRL_ONE) || (aw_addr_reg == `URT_OFF_CTRL_TWO) ||
               (aw_addr_reg == `URT_OFF_STATUS) || (aw_addr_reg == `URT_OFF_DATA) ||
               (aw_addr_reg == `URT_OFF_BAUD);
  reg [7:0] rd_mux; // Read data for the address on the read channel.
  reg rd_ok;

  // Read multiplexer; the ninth received bit shows in control one.
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `URT_OFF_CTRL_ONE: rd_mux = {ctrl_one_reg[7:2], rx_bit8_reg, 1'b0};
      `URT_OFF_CTRL_TWO: rd_mux = uart_ctrl_two_reg;
      `URT_OFF_STATUS: rd_mux = status;
      `URT_OFF_DATA: rd_mux = rx_data_reg;
      `URT_OFF_BAUD: rd_mux = baud_divisor_reg;
      default: begin
        rd_mux = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Address and data are taken in either order; the response follows both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `URT_RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok ? `URT_RESP_OKAY : `URT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after acceptance; the data pulse clears the full and overrun flags, the status pulse drives nothing.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `URT_RESP_OKAY;
      rd_stat_reg <= 1'b0;
      rd_data_reg <= 1'b0;
    end else begin
      rd_stat_reg <= 1'b0;
      rd_data_reg <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_mux};
        s_axi_rresp <= rd_ok ? `URT_RESP_OKAY : `URT_RESP_SLVERR;
        rd_stat_reg <= (s_axi_araddr == `URT_OFF_STATUS);
        rd_data_reg <= (s_axi_araddr == `URT_OFF_DATA);
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------
  // Baud generator and RX pin synchroniser
  //--------------------------------------------------------------------
  wire os_tick;
  // One tick source serves both directions.
  urt_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(master_en & ~uart_clk_off & (tx_run | rx_run)),
    .high_speed(uart_ctrl_two_reg[`URT_C2_HIGH]),
    .divisor(baud_divisor_reg),
    .os_tick(os_tick)
  );

  reg rx_meta_reg; // First synchroniser stage, read only by the second.
  reg rx_sync_reg; // Synchronised RX level.
  reg rx_prev_reg; // Previous synchronised level, for edge detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end
  // Wake only while the source clock is stopped and wake is enabled.
  wire wake_set = uart_clk_off & uart_ctrl_two_reg[`URT_C2_WAKE] & rx_prev_reg & ~rx_sync_reg;

  //--------------------------------------------------------------------
  // Transmitter
  //--------------------------------------------------------------------
  reg [1:0] tx_state_reg;
  reg [3:0] tx_os_reg; // Sub-bit tick count within a bit.
  reg [3:0] tx_bit_reg; // Data bits sent, or stop bits sent.
  reg [8:0] tx_shift_reg;
  reg [8:0] tx_word; // Frame payload with optional parity slot.
  reg tx_load; // Holding byte moved to the shifter this cycle.
  integer i;

  // Parity takes the last payload slot, as in the 7+P and 8+P formats.
  always @* begin
    tx_word = {tx_bit8, tx_hold_reg};
    if (parity_enable) begin
      tx_word[nbits - 4'd1] = parity_type;
      for (i = 0; i < 8; i = i + 1) begin
        if (i < nbits - 4'd1) begin
          tx_word[nbits - 4'd1] = tx_word[nbits - 4'd1] ^ tx_word[i];
        end
      end
    end
  end

  always @* begin
    tx_load = (tx_state_reg == ST_IDLE) & tx_run & ~tx_empty_reg;
  end

  // Frame sequencer; losing either enable resets it and floats the pin.
  always @(posedge aclk) begin
    if (!aresetn || !tx_run) begin
      tx_state_reg <= ST_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h1FF;
      tx_pin_o <= 1'b1;
      tx_pin_oe_n <= 1'b1;
    end else begin
      tx_pin_oe_n <= 1'b0;
      case (tx_state_reg)
        ST_IDLE: begin
          tx_pin_o <= 1'b1;
          if (tx_load) begin
            tx_shift_reg <= tx_word;
            tx_os_reg <= 4'h0;
            tx_state_reg <= ST_START;
          end
        end
        ST_START: begin
          tx_pin_o <= 1'b0;
          if (os_tick) begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == `URT_OS_LAST) begin
              tx_bit_reg <= 4'h0;
              tx_state_reg <= ST_BITS;
            end
          end
        end
        ST_BITS: begin
          tx_pin_o <= tx_shift_reg[0]; // LSB first.
          if (os_tick) begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == `URT_OS_LAST) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == nbits - 4'd1) begin
                tx_bit_reg <= 4'h0;
                tx_state_reg <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          tx_pin_o <= 1'b1; // Stop bits always sent, one or two.
          if (os_tick) begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == `URT_OS_LAST) begin
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == {3'b000, stop_bits_sel}) begin
                tx_state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Receiver
  //--------------------------------------------------------------------
  reg [1:0] rx_state_reg;
  reg [3:0] rx_os_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_shift_reg;
  reg rx_done_reg; // Pulse: a whole word has arrived.
  reg [8:0] rx_word_reg; // Arrived word, right aligned.
  assign rx_idle = (rx_state_reg == ST_IDLE);
  reg rx_par_bad;
  integer k; // Own loop index, so no variable is shared with the transmit side.

  // Parity check over the same slot layout the transmitter uses.
  always @* begin
    rx_par_bad = 1'b0;
    if (parity_enable) begin
      rx_par_bad = parity_type ^ rx_word_reg[nbits - 4'd1];
      for (k = 0; k < 8; k = k + 1) begin
        if (k < nbits - 4'd1) begin
          rx_par_bad = rx_par_bad ^ rx_word_reg[k];
        end
      end
    end
  end

  // Start is checked at mid-bit so a glitch does not open a frame; one stop
  // bit time is waited out, its level not checked. Disabling aborts and resets the sequencer.
  always @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_state_reg <= ST_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_done_reg <= 1'b0;
      rx_word_reg <= 9'h000;
      rx_pin_own <= 1'b0;
    end else begin
      rx_pin_own <= 1'b1;
      rx_done_reg <= 1'b0;
      case (rx_state_reg)
        ST_IDLE: begin
          rx_os_reg <= 4'h0;
          if (!rx_sync_reg) begin
            rx_state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == `URT_OS_MID) begin
              rx_os_reg <= 4'h0;
              rx_bit_reg <= 4'h0;
              rx_state_reg <= rx_sync_reg ? ST_IDLE : ST_BITS;
            end
          end
        end
        ST_BITS: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == `URT_OS_LAST) begin
              rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]}; // LSB first.
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == nbits - 4'd1) begin
                rx_state_reg <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == `URT_OS_LAST) begin
              rx_done_reg <= 1'b1;
              rx_word_reg <= nine_bit_sel ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
              rx_state_reg <= ST_IDLE;
            end
          end
        end
        default: rx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // Address bit is bit 7 in 8-bit mode, bit 8 in 9-bit mode.
  wire rx_addr_bit = nine_bit_sel ? rx_word_reg[8] : rx_word_reg[7];
  wire rx_keep = rx_done_reg & (~uart_ctrl_two_reg[`URT_C2_ADDR] | rx_addr_bit);

  //--------------------------------------------------------------------
  // Control registers and flags
  //--------------------------------------------------------------------
  // Accepted data write; it must also hold off the idle set in its own cycle.
  wire tx_wr = wr_en && (aw_addr_reg == `URT_OFF_DATA) && tx_empty_reg && tx_run;

  // Bus clears are applied first so a same-cycle hardware set wins; the disable clears at the end win over it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_reg <= `URT_CTRL_RST; // 8 data, no parity, one stop.
      uart_ctrl_two_reg <= `URT_CTRL_RST;
      baud_divisor_reg <= `URT_BAUD_RST;
      tx_hold_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_bit8_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      tx_idle_reg <= 1'b1;
      rx_full_reg <= 1'b0;
      rx_overrun_reg <= 1'b0;
      par_err_reg <= 1'b0;
      wake_flag_reg <= 1'b0;
      uart_irq <= 1'b0;
    end else begin
      if (wr_en && aw_addr_reg == `URT_OFF_CTRL_ONE) begin
        ctrl_one_reg <= {w_data_reg[7:2], 1'b0, w_data_reg[0]};
      end
      if (wr_en && aw_addr_reg == `URT_OFF_CTRL_TWO) begin
        uart_ctrl_two_reg <= w_data_reg;
      end
      if (wr_en && aw_addr_reg == `URT_OFF_BAUD) begin
        baud_divisor_reg <= w_data_reg;
      end
      if (wr_en && aw_addr_reg == `URT_OFF_STATUS && w_data_reg[`URT_ST_WAKE]) begin
        wake_flag_reg <= 1'b0;
      end
      // A write is accepted only while the holding register is empty.
      if (tx_wr) begin
        tx_hold_reg <= w_data_reg;
        tx_empty_reg <= 1'b0;
        tx_idle_reg <= 1'b0;
      end
      if (rd_data_reg) begin
        rx_full_reg <= 1'b0;
        rx_overrun_reg <= 1'b0;
      end
      // Hardware sets.
      if (tx_load) begin
        tx_empty_reg <= 1'b1;
      end
      if (tx_empty_reg && tx_state_reg == ST_IDLE && !tx_load && !tx_wr) begin
        tx_idle_reg <= 1'b1;
      end
      if (rx_keep) begin
        if (rx_full_reg && !rd_data_reg) begin
          rx_overrun_reg <= 1'b1;
        end else begin
          rx_data_reg <= rx_word_reg[7:0];
          rx_bit8_reg <= rx_word_reg[8];
          rx_full_reg <= 1'b1;
          par_err_reg <= rx_par_bad;
        end
      end
      if (wake_set) begin
        wake_flag_reg <= 1'b1;
      end
      // Transmit enable low empties the buffer; receive enable low flushes it.
      if (!tx_run) begin
        tx_empty_reg <= 1'b1;
        tx_idle_reg <= 1'b1;
      end
      if (!uart_ctrl_two_reg[`URT_C2_RX_ENABLE] || !master_en) begin
        rx_full_reg <= 1'b0;
        rx_overrun_reg <= 1'b0;
        par_err_reg <= 1'b0;
      end
      // Master disable also clears both direction enables.
      if (!master_en) begin
        uart_ctrl_two_reg[`URT_C2_TX_ENABLE] <= 1'b0;
        uart_ctrl_two_reg[`URT_C2_RX_ENABLE] <= 1'b0;
      end
      // Request line: the receive and both transmit sources pass through their own gates; the wake flag drives it ungated.
      uart_irq <= (uart_ctrl_two_reg[`URT_C2_RIE] & (rx_overrun_reg | rx_full_reg)) |
                  (uart_ctrl_two_reg[`URT_C2_TX_IDLE_IRQ_EN] & tx_idle_reg) |
                  (uart_ctrl_two_reg[`URT_C2_TX_EMPTY_IRQ_EN] & tx_empty_reg) |
                  wake_flag_reg;
    end
  end

endmodule // urt_top

// *** inc/urt_defs.vh ***
// Constant definitions for the UART control, data and baud-rate block.
//--------------------------------------------------------------------
//--------------------------------------------------------------------
`ifndef URT_DEFS_VH
`define URT_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define URT_ADDR_W 8
`define URT_OFF_CTRL_ONE 8'h00
`define URT_OFF_CTRL_TWO 8'h04
`define URT_OFF_STATUS 8'h08
`define URT_OFF_DATA 8'h0C
`define URT_OFF_BAUD 8'h10

// Control-one bit positions.
`define URT_C1_MASTER 7
`define URT_C1_NINE 6
`define URT_C1_PAR_EN 5
`define URT_C1_PAR_ODD 4
`define URT_C1_STOP2 3
`define URT_C1_RXB8 1
`define URT_C1_TXB8 0

// Control-two bit positions.
`define URT_C2_TX_ENABLE 7
`define URT_C2_RX_ENABLE 6
`define URT_C2_HIGH 5
`define URT_C2_ADDR 4
`define URT_C2_WAKE 3
`define URT_C2_RIE 2
`define URT_C2_TX_IDLE_IRQ_EN 1
`define URT_C2_TX_EMPTY_IRQ_EN 0

// Status bit positions.
`define URT_ST_WAKE 6

// Reset values.
`define URT_CTRL_RST 8'h00
`define URT_BAUD_RST 8'h00

// Oversampling: sixteen sub-bit ticks per bit, sample at the middle.
`define URT_OS_LAST 4'hF
`define URT_OS_MID 4'h7
`define URT_PRE_LOW 2'h3

// Payload slots per frame in the two word-length modes.
`define URT_NBITS_NINE 4'h9
`define URT_NBITS_EIGHT 4'h8

// AXI responses.
`define URT_RESP_OKAY 2'b00
`define URT_RESP_SLVERR 2'b10

`endif

// *** hw/urt_baud_gen.v ***
// Baud-rate generator: prescaler plus free-running 8-bit reload timer.
`timescale 1ns/1ns
`include "urt_defs.vh"

module urt_baud_gen (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire high_speed,
  input wire [7:0] divisor,
  output reg os_tick
);

  //--------------------------------------------------------------------
  // Counters
  //--------------------------------------------------------------------
  reg [1:0] pre_reg; // Divide-by-four prescaler for the low speed mode.
  reg [7:0] timer_reg; // Down-counting 8-bit timer.

  wire pre_done = high_speed | (pre_reg == `URT_PRE_LOW);

  // The timer counts N+1 prescaled steps, so a sub-bit tick comes every
  // 4(N+1) or (N+1) clocks; sixteen ticks make one bit.
  // Stopping resets the counters so a re-enable starts a fresh period.
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_reg <= 2'h0;
      timer_reg <= 8'h00;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      pre_reg <= pre_done ? 2'h0 : pre_reg + 2'h1;
      if (pre_done) begin
        if (timer_reg == 8'h00) begin
          timer_reg <= divisor; // Reload from N at terminal count.
          os_tick <= 1'b1;
        end else begin
          timer_reg <= timer_reg - 8'h01;
        end
      end
    end
  end

endmodule // urt_baud_gen

// *** test/urt_props.sv ***
// Port-level checker for the UART control block.
`timescale 1ns/1ns
module urt_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_pin_o,
  input wire tx_pin_oe_n,
  input wire rx_pin_own
);
  // ----------------------------------------
  // Assertions on the single bus clock.
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A response must stand until the master takes it.
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data wider than a byte");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  b_after_aw_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready)
    else $error("write response without address take");
  // The shortest bit is sixteen clocks, so a start bit stays low at least eight.
  start_len_a: assert property ($fell(tx_pin_o) && !tx_pin_oe_n |-> (!tx_pin_o)[*8])
    else $error("start bit too short");
  pins_reset_a: assert property ($rose(aresetn) |-> tx_pin_oe_n && !rx_pin_own)
    else $error("pins owned out of reset");
  // TX pin ownership follows only from a control write in flight; RX ownership also follows uart_clk_off.
  own_cause_a: assert property ($changed(tx_pin_oe_n) || $changed(rx_pin_own) |->
    !s_axi_awready || !$past(s_axi_awready) || !$past(s_axi_awready, 2))
    else $error("pin ownership changed without a write");
endmodule // urt_props
bind urt_top urt_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_pin_o, .tx_pin_oe_n, .rx_pin_own);

// *** test/urt_remote.sv ***
// Remote serial node model facing the TX and RX pins.
`timescale 1ns/1ns
module urt_remote (
  input wire aclk,
  input wire [7:0] bit_clks,
  input wire tx_line,
  output reg rx_line,
  output reg [7:0] got_byte,
  output reg got_stop,
  output reg [7:0] got_cnt
);
  // ----------------------------------------
  // Frame sender and decoder, format 8N1.
  // ----------------------------------------
  integer i;
  integer j;
  reg [9:0] frm;
  initial begin
    rx_line = 1'b1;
    got_byte = 8'h00;
    got_stop = 1'b0;
    got_cnt = 8'h00;
  end
  // Start bit, eight bits least significant first, one stop; idles high.
  task send(input [7:0] d);
    begin
      frm = {1'b1, d, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        rx_line <= frm[i];
        repeat (bit_clks) @(posedge aclk);
      end
    end
  endtask
  // Decode at mid-bit; a frame cut short still ends nine and a half bit times after its falling edge.
  always @(negedge tx_line) begin
    repeat (bit_clks / 2) @(posedge aclk);
    for (j = 0; j < 8; j = j + 1) begin
      repeat (bit_clks) @(posedge aclk);
      got_byte[j] <= tx_line;
    end
    repeat (bit_clks) @(posedge aclk);
    got_stop <= tx_line;
    got_cnt <= got_cnt + 8'h01;
  end
endmodule // urt_remote

// *** test/testbench.sv ***
// Self-checking bench for the UART control block.
`timescale 1ns/1ns
`include "urt_defs.vh"
`define CHK(nm, e, g) begin n_compared = n_compared + 1; if ((g) !== (e)) begin fails = fails + 1; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg uart_clk_off = 1'b0;
  reg [7:0] bit_clks = 8'h40;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire rx_pin_i, tx_pin_o, tx_pin_oe_n, rx_pin_own, uart_irq, got_stop;
  wire [7:0] got_byte, got_cnt;
  // A floating TX line is pulled high, as a real board would.
  wire tx_line = tx_pin_oe_n ? 1'b1 : tx_pin_o;
  integer fails = 0, n_compared = 0, cyc = 0;
  reg [31:0] rv;
  reg [1:0] rr;
  reg [7:0] n;
  urt_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .uart_clk_off, .rx_pin_i, .tx_pin_o, .tx_pin_oe_n, .rx_pin_own, .uart_irq);
  urt_remote rem (.aclk, .bit_clks, .tx_line, .rx_line(rx_pin_i), .got_byte, .got_stop, .got_cnt);
  // ----------------------------------------
  // Bus tasks: hold each channel until taken.
  // ----------------------------------------
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rr = s_axi_bresp;
      repeat (4) @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      repeat (4) @(posedge aclk);
    end
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task t_reset;
    begin
      rd(`URT_OFF_CTRL_TWO);
      `CHK("ctrl_two", 32'h0000_0000, rv)
      rd(`URT_OFF_CTRL_ONE);
      `CHK("ctrl_one", 32'h0000_0000, rv)
      rd(8'h14);
      `CHK("rd_unmapped", `URT_RESP_SLVERR, rr)
      wr(8'h14, 8'h5A);
      `CHK("wr_unmapped", `URT_RESP_SLVERR, rr)
      $display("t_reset done");
    end
  endtask
  // High speed, divisor one: a bit lasts 16*2 clocks; then abort mid-frame.
  task t_tx;
    begin
      wr(`URT_OFF_CTRL_ONE, 8'h80);
      wr(`URT_OFF_BAUD, 8'h01);
      wr(`URT_OFF_CTRL_TWO, 8'hA0);
      bit_clks <= 8'h20;
      `CHK("tx_driven", 1'b0, tx_pin_oe_n)
      n = got_cnt;
      wr(`URT_OFF_DATA, 8'hA5);
      rd(`URT_OFF_STATUS);
      `CHK("tx_busy", 32'h0000_0000, rv & 32'h0000_0002)
      while (got_cnt == n) @(posedge aclk);
      `CHK("tx_byte", 8'hA5, got_byte)
      `CHK("tx_stop", 1'b1, got_stop)
      wr(`URT_OFF_DATA, 8'h0F);
      repeat (100) @(posedge aclk);
      wr(`URT_OFF_CTRL_TWO, 8'h00);
      `CHK("tx_abort", 1'b1, tx_pin_oe_n)
      repeat (400) @(posedge aclk);
      $display("t_tx done");
    end
  endtask
  // Low speed, divisor zero: 64 clocks a bit; receive, interrupt gates.
  task t_rx;
    begin
      wr(`URT_OFF_BAUD, 8'h00);
      wr(`URT_OFF_CTRL_TWO, 8'h44);
      bit_clks <= 8'h40;
      `CHK("rx_owned", 1'b1, rx_pin_own)
      `CHK("irq_masked", 1'b0, uart_irq)
      rem.send(8'h3C);
      repeat (8) @(posedge aclk);
      `CHK("irq_rx", 1'b1, uart_irq)
      rd(`URT_OFF_DATA);
      `CHK("rx_byte", 32'h0000_003C, rv)
      `CHK("irq_clr", 1'b0, uart_irq)
      wr(`URT_OFF_CTRL_TWO, 8'h54);
      rem.send(8'h3C);
      repeat (8) @(posedge aclk);
      `CHK("addr_drop", 1'b0, uart_irq)
      rem.send(8'hA5);
      repeat (8) @(posedge aclk);
      `CHK("addr_keep", 1'b1, uart_irq)
      rd(`URT_OFF_DATA);
      `CHK("addr_byte", 32'h0000_00A5, rv)
      wr(`URT_OFF_CTRL_TWO, 8'h81);
      `CHK("irq_empty", 1'b1, uart_irq)
      wr(`URT_OFF_CTRL_TWO, 8'h00);
      `CHK("rx_free", 1'b0, rx_pin_own)
      `CHK("irq_off", 1'b0, uart_irq)
      $display("t_rx done");
    end
  endtask
  // RX fall wakes only with the source clock stopped and wake enabled.
  task t_wake;
    begin
      wr(`URT_OFF_CTRL_TWO, 8'h08);
      rem.send(8'hFF);
      `CHK("wake_clk_on", 1'b0, uart_irq)
      uart_clk_off <= 1'b1;
      rem.send(8'hFF);
      rd(`URT_OFF_STATUS);
      `CHK("wake_flag", 32'h0000_0040, rv & 32'h0000_0040)
      `CHK("wake_irq", 1'b1, uart_irq)
      wr(`URT_OFF_STATUS, 8'h40);
      wr(`URT_OFF_CTRL_TWO, 8'h00);
      rem.send(8'hFF);
      `CHK("wake_off", 1'b0, uart_irq)
      uart_clk_off <= 1'b0;
      $display("t_wake done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Clock, hang guard and main sequence.
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_wake;
    tally_and_finish;
  end
endmodule // testbench
